// file: logic/oprc_ring_ctrl.sv
// Operation
// [RULE_01] Writing one to resume restarts the whole receive direction.
// [RULE_02] Engine clears the resume bit once reception has restarted.
// [RULE_03] A full receive ring halts all reception until resume.
// [RULE_04] Writing one to send takes one packet from the transmit ring.
// [RULE_05] Send bit reads one while sending, cleared by engine when done.
// [RULE_06] 16-bit descriptor page pointer in two bytes locates both rings.
// [RULE_07] Idle gap of count times 64 clocks after every 256 DMA bytes; the pacer's byte count restarts with each packet.
// [RULE_08] Gap register initial value comes from the EEPROM configuration.
// [RULE_09] Collision flag set when both ARP hash lookups hit foreign slots.
// [RULE_10] Nonempty flag set while a received packet sits in the ring.
// [RULE_11] Full flag set when a packet lacks enough free ring pages.
// [RULE_12] ARP miss sends an ARP request instead and sets the miss flag.
// [RULE_13] Send with empty transmit ring sets the transmit empty flag.
// [RULE_14] Done flag set once the one requested packet has been sent.
// [RULE_15] Each status flag drives the interrupt when its enable is one.
// [RULE_16] A ring is empty when tail pointer equals head pointer.
// [RULE_17] Storing a packet cuts free pages and advances the tail.
// [RULE_18] Reading status clears flags, but a same-cycle set survives.
// [RULE_19] Writing zero to a command bit does nothing.
`timescale 1ns/1ps
module oprc_ring_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  eeprom_gap_value,
  input  wire logic        eeprom_gap_load,
  output logic      [15:0] descriptor_page_ptr,
  input  wire logic [15:0] rx_start_ptr,
  input  wire logic [15:0] rx_end_ptr,
  input  wire logic [15:0] rx_head_pointer,
  input  wire logic [15:0] rx_tail_pointer,
  input  wire logic [7:0]  rx_free_page_count,
  input  wire logic [15:0] tx_start_ptr,
  input  wire logic [15:0] tx_end_ptr,
  input  wire logic [15:0] tx_head_ptr,
  input  wire logic [15:0] tx_tail_ptr,
  input  wire logic [7:0]  tx_pkt_pages,
  input  wire logic        rx_pkt_req,
  input  wire logic [7:0]  rx_pkt_pages,
  output logic             rx_pkt_grant,
  output logic             rx_halted,
  input  wire logic        dma_valid,
  input  wire logic        dma_last,
  output logic             dma_ready,
  output logic             dma_rx_dir,
  output logic             arp_lookup_req,
  input  wire logic        arp_done,
  input  wire logic        arp_hit,
  input  wire logic        arp_collision,
  output logic             tx_send_arp,
  output logic             ring_wb,
  output logic             ring_wb_rx,
  output logic      [15:0] ring_wb_ptr,
  output logic      [7:0]  ring_wb_free,
  output logic             offload_irq_line
);

  typedef struct packed {
    oprc_pkg::oprc_state_t st;
    logic [7:0]            rdata;
    logic                  resume_receive_cmd;
    logic                  send_packet_cmd;
    logic [15:0]           buffer_descriptor_page;
    logic [7:0]            gap;
    logic [7:0]            status;
    logic [7:0]            irq_en;
    logic                  halted;
    logic                  arp_req;
    logic                  wb;
    logic                  wb_rx;
    logic [15:0]           wb_ptr;
    logic [7:0]            wb_free;
  } oprc_ctrl_t;

  oprc_ctrl_t s_reg;
  oprc_ctrl_t s_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       pause;
  logic       beat;
  logic       rx_room;
  logic [7:0] set_vec;

  // Advance a page pointer inside a ring that wraps at its end page
  function automatic logic [15:0] ring_adv(input logic [15:0] ptr,
                                           input logic [7:0]  pages,
                                           input logic [15:0] start,
                                           input logic [15:0] stop);
    logic [16:0] sum;
    sum = {1'b0, ptr} + {9'h000, pages};
    if (sum >= {1'b0, stop})
      sum = sum - {1'b0, stop} + {1'b0, start};
    return sum[15:0];
  endfunction : ring_adv

  ////////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  oprc_gap_pacer u_pacer (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .active    (s_reg.st == oprc_pkg::OPRC_RX_DMA ||
                s_reg.st == oprc_pkg::OPRC_TX_DMA),
    .beat      (beat),
    .gap_count (s_reg.gap),
    .pause     (pause)
  );

  // Handshake outputs, combinational
  assign dma_ready = (s_reg.st == oprc_pkg::OPRC_RX_DMA ||
                      s_reg.st == oprc_pkg::OPRC_TX_DMA) && !pause; // see [RULE_07]
  assign beat      = dma_valid && dma_ready;
  assign rx_room   = rx_free_page_count >= rx_pkt_pages;
  assign rx_pkt_grant = (s_reg.st == oprc_pkg::OPRC_IDLE) && rx_pkt_req
                        && !s_reg.halted && rx_room; // see [RULE_03]
  assign arp_lookup_req = s_reg.st == oprc_pkg::OPRC_TX_ARP;

  // Registered outputs
  assign reg_rdata           = s_reg.rdata;
  assign descriptor_page_ptr = s_reg.buffer_descriptor_page; // see [RULE_06]
  assign rx_halted           = s_reg.halted;
  assign dma_rx_dir          = s_reg.st == oprc_pkg::OPRC_RX_DMA;
  assign tx_send_arp         = s_reg.arp_req;
  assign ring_wb             = s_reg.wb;
  assign ring_wb_rx          = s_reg.wb_rx;
  assign ring_wb_ptr         = s_reg.wb_ptr;
  assign ring_wb_free        = s_reg.wb_free;
  assign offload_irq_line    = |(s_reg.status & s_reg.irq_en); // see [RULE_15]

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next    = s_reg;
    s_next.wb = 1'b0;
    set_vec   = 8'h00;

    // Ring holds a packet while tail and head differ
    set_vec[oprc_pkg::ST_RX_NONEMPTY] =
      rx_tail_pointer != rx_head_pointer; // see [RULE_10] [RULE_16]

    // Resume takes effect at once; halt lifted, bit self-clears
    if (s_reg.resume_receive_cmd)
    begin
      s_next.halted             = 1'b0; // see [RULE_01]
      s_next.resume_receive_cmd = 1'b0; // see [RULE_02]
    end

    case (s_reg.st)
      oprc_pkg::OPRC_IDLE:
      begin
        if (rx_pkt_req && !s_reg.halted && !rx_room)
        begin
          s_next.halted = 1'b1; // see [RULE_03]
          set_vec[oprc_pkg::ST_RX_FULL] = 1'b1; // see [RULE_11]
        end
        else if (rx_pkt_grant)
          s_next.st = oprc_pkg::OPRC_RX_DMA;
        else if (s_reg.send_packet_cmd)
          s_next.st = oprc_pkg::OPRC_TX_CHECK; // see [RULE_04]
      end
      oprc_pkg::OPRC_RX_DMA:
      begin
        if (beat && dma_last)
        begin
          // Room was only checked at grant; commit tail and free count now
          s_next.wb      = 1'b1;
          s_next.wb_rx   = 1'b1;
          s_next.wb_ptr  = ring_adv(rx_tail_pointer, rx_pkt_pages,
                                    rx_start_ptr, rx_end_ptr); // see [RULE_17]
          s_next.wb_free = rx_free_page_count - rx_pkt_pages; // see [RULE_17]
          s_next.st      = oprc_pkg::OPRC_IDLE;
        end
      end
      oprc_pkg::OPRC_TX_CHECK:
      begin
        if (tx_tail_ptr == tx_head_ptr)
        begin
          set_vec[oprc_pkg::ST_TX_EMPTY] = 1'b1; // see [RULE_13] [RULE_16]
          s_next.send_packet_cmd = 1'b0;
          s_next.st              = oprc_pkg::OPRC_IDLE;
        end
        else
          s_next.st = oprc_pkg::OPRC_TX_ARP;
      end
      oprc_pkg::OPRC_TX_ARP:
      begin
        if (arp_done)
        begin
          set_vec[oprc_pkg::ST_COLLISION_BIT] = arp_collision; // see [RULE_09]
          set_vec[oprc_pkg::ST_ARP_MISS]      = !arp_hit; // see [RULE_12]
          s_next.arp_req = !arp_hit; // see [RULE_12]
          s_next.st      = oprc_pkg::OPRC_TX_DMA;
        end
      end
      oprc_pkg::OPRC_TX_DMA:
      begin
        if (beat && dma_last)
        begin
          s_next.wb      = 1'b1;
          s_next.wb_rx   = 1'b0;
          s_next.wb_ptr  = ring_adv(tx_head_ptr, tx_pkt_pages,
                                    tx_start_ptr, tx_end_ptr);
          s_next.wb_free = tx_pkt_pages;
          s_next.arp_req = 1'b0;
          s_next.send_packet_cmd = 1'b0; // see [RULE_05]
          set_vec[oprc_pkg::ST_TX_DONE] = 1'b1; // see [RULE_14]
          s_next.st = oprc_pkg::OPRC_IDLE;
        end
      end
      default:
        s_next.st = oprc_pkg::OPRC_IDLE;
    endcase

    // Register writes; zeros to command bits are ignored
    if (reg_wr)
    begin
      case (reg_addr)
        oprc_pkg::ADDR_COMMAND:
        begin
          if (reg_wdata[oprc_pkg::CMD_RESUME_BIT])
            s_next.resume_receive_cmd = 1'b1; // see [RULE_01] [RULE_19]
          if (reg_wdata[oprc_pkg::CMD_SEND_BIT])
            s_next.send_packet_cmd = 1'b1; // see [RULE_04] [RULE_19]
        end
        oprc_pkg::ADDR_BDP_LO: s_next.buffer_descriptor_page[7:0]  = reg_wdata; // see [RULE_06]
        oprc_pkg::ADDR_BDP_HI: s_next.buffer_descriptor_page[15:8] = reg_wdata; // see [RULE_06]
        oprc_pkg::ADDR_GAP:    s_next.gap       = reg_wdata;
        oprc_pkg::ADDR_IRQ_EN: s_next.irq_en    = reg_wdata;
        oprc_pkg::ADDR_STATUS:
          s_next.status = s_reg.status & ~reg_wdata;
        default:
          s_next.buffer_descriptor_page = s_next.buffer_descriptor_page;
      endcase
    end

    // EEPROM config strap: caught after reset release, not under reset
    if (eeprom_gap_load)
      s_next.gap = eeprom_gap_value; // see [RULE_08]

    // Read side effects: status clears, new events win
    if (reg_rd && reg_addr == oprc_pkg::ADDR_STATUS)
      s_next.status = 8'h00; // see [RULE_18]
    s_next.status = (s_next.status | set_vec)
                    & oprc_pkg::STATUS_USED_MASK; // see [RULE_18]

    // Read data, valid the cycle after the strobe only
    s_next.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        oprc_pkg::ADDR_COMMAND:
        begin
          s_next.rdata[oprc_pkg::CMD_RESUME_BIT] = s_reg.resume_receive_cmd;
          s_next.rdata[oprc_pkg::CMD_SEND_BIT]   =
            s_reg.send_packet_cmd; // see [RULE_05]
        end
        oprc_pkg::ADDR_BDP_LO: s_next.rdata = s_reg.buffer_descriptor_page[7:0];
        oprc_pkg::ADDR_BDP_HI: s_next.rdata = s_reg.buffer_descriptor_page[15:8];
        oprc_pkg::ADDR_GAP:    s_next.rdata = s_reg.gap;
        oprc_pkg::ADDR_STATUS: s_next.rdata = s_reg.status;
        oprc_pkg::ADDR_IRQ_EN: s_next.rdata = s_reg.irq_en;
        default:               s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg        <= '0;
      s_reg.st     <= oprc_pkg::OPRC_IDLE;
      s_reg.rdata  <= oprc_pkg::RDATA_RESET;
      s_reg.buffer_descriptor_page    <= oprc_pkg::BDP_RESET;
      s_reg.gap    <= oprc_pkg::GAP_RESET;
      s_reg.status <= oprc_pkg::STATUS_RESET;
      s_reg.irq_en <= oprc_pkg::IRQ_EN_RESET;
    end
    else if (ce)
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_resume_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.resume_receive_cmd && !(reg_wr &&
     reg_addr == oprc_pkg::ADDR_COMMAND && reg_wdata[0]))
    |=> !s_reg.resume_receive_cmd && !s_reg.halted) // see [RULE_02]
    else $error("resume bit or halt not cleared");

  a_full_halts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.st == oprc_pkg::OPRC_IDLE && rx_pkt_req && !s_reg.halted
     && !rx_room && !s_reg.resume_receive_cmd)
    |=> s_reg.halted && s_reg.status[oprc_pkg::ST_RX_FULL]) // see [RULE_03]
    else $error("full ring did not halt reception");

  a_halt_no_grant: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_reg.halted |-> !rx_pkt_grant) // see [RULE_03]
    else $error("grant while receive halted");

  a_send_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.send_packet_cmd && s_reg.st == oprc_pkg::OPRC_TX_ARP)
    |=> s_reg.send_packet_cmd) // see [RULE_05]
    else $error("send bit dropped before completion");

  a_tx_empty_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.st == oprc_pkg::OPRC_TX_CHECK && tx_tail_ptr == tx_head_ptr
     && !(reg_wr && reg_addr == oprc_pkg::ADDR_COMMAND && reg_wdata[4]))
    |=> s_reg.status[oprc_pkg::ST_TX_EMPTY] && !s_reg.send_packet_cmd
        && s_reg.st == oprc_pkg::OPRC_IDLE) // see [RULE_13]
    else $error("empty transmit ring not flagged");

  a_tx_done_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.st == oprc_pkg::OPRC_TX_DMA && beat && dma_last)
    |=> s_reg.status[oprc_pkg::ST_TX_DONE] && s_reg.wb
        && !s_reg.wb_rx) // see [RULE_14]
    else $error("transmit done not flagged");

  a_rx_free_wb: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.st == oprc_pkg::OPRC_RX_DMA && beat && dma_last)
    |=> s_reg.wb && s_reg.wb_rx && s_reg.wb_free ==
        $past(rx_free_page_count) - $past(rx_pkt_pages)) // see [RULE_17]
    else $error("free page count not reduced");

  a_irq_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_reg.status[oprc_pkg::ST_TX_DONE] && s_reg.irq_en[oprc_pkg::ST_TX_DONE])
    |-> offload_irq_line) // see [RULE_15]
    else $error("enabled flag did not raise interrupt");

  a_read_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && reg_rd && reg_addr == oprc_pkg::ADDR_STATUS
     && s_reg.st == oprc_pkg::OPRC_TX_ARP && !arp_done)
    |=> !s_reg.status[oprc_pkg::ST_ARP_MISS]
        && reg_rdata == $past(s_reg.status)) // see [RULE_18]
    else $error("status read did not clear flags");

  a_arp_miss: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && s_reg.st == oprc_pkg::OPRC_TX_ARP && arp_done && !arp_hit)
    |=> tx_send_arp && s_reg.status[oprc_pkg::ST_ARP_MISS]) // see [RULE_12]
    else $error("ARP miss not handled");

endmodule : oprc_ring_ctrl

// file: logic/oprc_pkg.sv
package oprc_pkg;

  // Register byte offsets on the 8-bit register port
  localparam logic [7:0] ADDR_COMMAND  = 8'h21;
  localparam logic [7:0] ADDR_BDP_LO   = 8'h22;
  localparam logic [7:0] ADDR_BDP_HI   = 8'h23;
  localparam logic [7:0] ADDR_GAP      = 8'h24;
  localparam logic [7:0] ADDR_STATUS   = 8'h30;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h31;

  // Command bit positions
  localparam int CMD_RESUME_BIT = 0;
  localparam int CMD_SEND_BIT   = 4;

  // Status bit positions, shared by the interrupt enable register
  localparam int ST_COLLISION_BIT = 0;
  localparam int ST_RX_NONEMPTY   = 1;
  localparam int ST_RX_FULL       = 2;
  localparam int ST_ARP_MISS      = 4;
  localparam int ST_TX_EMPTY      = 5;
  localparam int ST_TX_DONE       = 6;
  localparam logic [7:0] STATUS_USED_MASK = 8'h77;

  // Values after reset
  localparam logic [15:0] BDP_RESET    = 16'h0000;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  IRQ_EN_RESET = 8'h00;
  localparam logic [7:0]  GAP_RESET    = 8'h00;
  localparam logic [7:0]  RDATA_RESET  = 8'h00;

  // Pacing: one idle gap after each burst, gap unit in system clocks
  localparam int          BURST_BYTES     = 256;
  localparam logic [7:0]  BURST_LAST_BYTE = 8'(BURST_BYTES - 1);
  localparam int          GAP_UNIT_CLOCKS = 64;
  localparam int          GAP_UNIT_SHIFT  = $clog2(GAP_UNIT_CLOCKS);
  localparam int          GAP_CNT_W       = 8 + GAP_UNIT_SHIFT;

  typedef enum logic [2:0] {
    OPRC_IDLE,
    OPRC_RX_DMA,
    OPRC_TX_CHECK,
    OPRC_TX_ARP,
    OPRC_TX_DMA
  } oprc_state_t;

endpackage : oprc_pkg

// file: logic/oprc_gap_pacer.sv
`timescale 1ns/1ps
module oprc_gap_pacer (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       active,
  input  wire logic       beat,
  input  wire logic [7:0] gap_count,
  output logic            pause
);

  typedef struct packed {
    logic [7:0]                      byte_cnt;
    logic [oprc_pkg::GAP_CNT_W-1:0] gap_cnt;
    logic                            paused;
  } oprc_pacer_t;

  oprc_pacer_t s_reg;
  oprc_pacer_t s_next;

  assign pause = s_reg.paused;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next = s_reg;
    if (!active)
    begin
      // Burst count restarts with each packet
      s_next = '0;
    end
    else if (s_reg.paused)
    begin
      if (s_reg.gap_cnt == '0)
        s_next.paused = 1'b0;
      else
        s_next.gap_cnt = s_reg.gap_cnt - 1'b1;
    end
    else if (beat)
    begin
      s_next.byte_cnt = s_reg.byte_cnt + 8'h01;
      if (s_reg.byte_cnt == oprc_pkg::BURST_LAST_BYTE && gap_count != 8'h00)
      begin
        // Preload is count times the unit minus one; the exit cycle ends the gap
        s_next.paused  = 1'b1; // see [RULE_07]
        s_next.gap_cnt = {gap_count, oprc_pkg::GAP_UNIT_SHIFT'(0)}
                         - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_reg <= '0;
    else if (ce)
      s_reg <= s_next;
  end

  a_gap_starts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (ce && active && !s_reg.paused && beat && gap_count != 8'h00
     && s_reg.byte_cnt == oprc_pkg::BURST_LAST_BYTE)
    |=> pause) // see [RULE_07]
    else $error("gap not started after a full burst");

endmodule : oprc_gap_pacer

// file: verif/oprc_far_model.sv
`timescale 1ns/1ps
module oprc_far_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        rx_start,
  input  wire logic [15:0] pkt_len,
  input  wire logic [7:0]  arp_dly,
  input  wire logic        hit_cfg,
  input  wire logic        coll_cfg,
  input  wire logic        rx_pkt_grant,
  input  wire logic        dma_ready,
  input  wire logic        arp_lookup_req,
  output logic             rx_pkt_req,
  output logic             dma_valid,
  output logic             dma_last,
  output logic             arp_done,
  output logic             arp_hit,
  output logic             arp_collision
);
  logic [15:0] cnt;
  logic [7:0]  wt;
  logic        active;
  ////////////////////////////////////////////////////////////////////////////
  assign dma_valid = active;
  assign dma_last = active && (cnt == pkt_len - 16'h0001);
  // Inverse outside the answer cycle, so a stale sample shows up
  assign arp_hit = arp_done ? hit_cfg : !hit_cfg;
  assign arp_collision = arp_done ? coll_cfg : !coll_cfg;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_pkt_req <= 1'b0;
      arp_done <= 1'b0;
      active <= 1'b0;
      cnt <= 16'h0000;
      wt <= 8'h00;
    end
    else
    begin
      if (rx_start)
        rx_pkt_req <= 1'b1;
      else if (rx_pkt_grant)
        rx_pkt_req <= 1'b0;
      if (rx_pkt_grant)
      begin
        active <= 1'b1;
        cnt <= 16'h0000;
      end
      else if (active && dma_ready)
      begin
        // Valid held through a gap pause until ready returns
        cnt <= cnt + 16'h0001;
        if (dma_last)
          active <= 1'b0;
      end
      if (arp_done)
      begin
        arp_done <= 1'b0;
        active <= 1'b1;
        cnt <= 16'h0000;
        wt <= 8'h00;
      end
      else if (arp_lookup_req)
      begin
        if (wt == arp_dly)
          arp_done <= 1'b1;
        else
          wt <= wt + 8'h01;
      end
      else
        wt <= 8'h00;
    end
  end
endmodule : oprc_far_model

// file: verif/offload_packet_ring_control_tb_top.sv
`timescale 1ns/1ps
module offload_packet_ring_control_tb_top;
  logic        sys_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic [7:0]  gap_val = 8'h00;
  logic        gap_load = 1'b0;
  logic [15:0] buffer_descriptor_page;
  logic [15:0] rx_head = 16'h0010;
  logic [15:0] rx_tail = 16'h0010;
  logic [7:0]  rx_free = 8'h08;
  logic [15:0] tx_head = 16'h0050;
  logic [15:0] tx_tail = 16'h0050;
  logic [7:0]  tx_pages = 8'h02;
  logic [7:0]  rx_pages = 8'h02;
  logic        rx_req, grant, halted, dvalid, dlast, dready, rx_dir;
  logic        arp_req, arp_done, arp_hit, arp_coll, send_arp;
  logic        wb, wb_rx, irq;
  logic [15:0] wb_ptr;
  logic [7:0]  wb_free;
  logic        rx_start = 1'b0;
  logic [15:0] pkt_len = 16'd300;
  logic [7:0]  arp_dly = 8'h00;
  logic        hit_cfg = 1'b0;
  logic        coll_cfg = 1'b0;
  logic        rd_pend = 1'b0;
  logic        seen_arp = 1'b0;
  logic [7:0]  rd_q [$];
  logic [24:0] wb_q [$];
  logic [15:0] p;
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_wb = 0;
  int          stall_n = 0;
  localparam logic [7:0] RST_ADDR [7] = '{8'h21, 8'h22, 8'h23, 8'h24,
                                          8'h30, 8'h31, 8'h40};
  ////////////////////////////////////////////////////////////////////////////
  always #50 sys_clk = !sys_clk;
  oprc_ring_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .ce(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eeprom_gap_value(gap_val),
    .eeprom_gap_load(gap_load), .descriptor_page_ptr(buffer_descriptor_page),
    .rx_start_ptr(16'h0010), .rx_end_ptr(16'h0040),
    .rx_head_pointer(rx_head), .rx_tail_pointer(rx_tail),
    .rx_free_page_count(rx_free), .tx_start_ptr(16'h0050),
    .tx_end_ptr(16'h0080), .tx_head_ptr(tx_head), .tx_tail_ptr(tx_tail),
    .tx_pkt_pages(tx_pages), .rx_pkt_req(rx_req), .rx_pkt_pages(rx_pages),
    .rx_pkt_grant(grant), .rx_halted(halted), .dma_valid(dvalid),
    .dma_last(dlast), .dma_ready(dready), .dma_rx_dir(rx_dir),
    .arp_lookup_req(arp_req), .arp_done(arp_done), .arp_hit(arp_hit),
    .arp_collision(arp_coll), .tx_send_arp(send_arp), .ring_wb(wb),
    .ring_wb_rx(wb_rx), .ring_wb_ptr(wb_ptr), .ring_wb_free(wb_free),
    .offload_irq_line(irq));
  oprc_far_model far_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .rx_start(rx_start), .pkt_len(pkt_len), .arp_dly(arp_dly),
    .hit_cfg(hit_cfg), .coll_cfg(coll_cfg), .rx_pkt_grant(grant),
    .dma_ready(dready), .arp_lookup_req(arp_req), .rx_pkt_req(rx_req),
    .dma_valid(dvalid), .dma_last(dlast), .arp_done(arp_done),
    .arp_hit(arp_hit), .arp_collision(arp_coll));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(exp);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic pulse_rx();
    @(posedge sys_clk);
    rx_start <= 1'b1;
    @(posedge sys_clk);
    rx_start <= 1'b0;
  endtask : pulse_rx
  task automatic wait_wb();
    int target;
    target = n_wb + 1;
    for (int i = 0; i < 4000; i++)
    begin
      @(posedge sys_clk);
      if (n_wb >= target)
        return;
    end
    n_mismatch++;
    end_sim();
  endtask : wait_wb
  ////////////////////////////////////////////////////////////////////////////
  // Results are judged half a cycle after the edge, when settled
  always @(posedge sys_clk)
  begin
    rd_pend <= reg_rd;
    if (dvalid && !dready)
      stall_n <= stall_n + 1;
    if (dvalid && dready && !rx_dir)
      seen_arp <= send_arp;
  end
  always @(negedge sys_clk)
  begin
    if (rd_pend)
      check({17'h0, reg_rdata}, {17'h0, rd_q.pop_front()});
    if (wb)
    begin
      check({wb_rx, wb_ptr, wb_free}, wb_q.pop_front());
      n_wb++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    void'($urandom(32'he54c06c0));
    foreach (RST_ADDR[i])
      rd(RST_ADDR[i], 8'h00);
    @(posedge sys_clk);
    gap_val <= 8'($urandom);
    gap_load <= 1'b1;
    @(posedge sys_clk);
    gap_load <= 1'b0;
    rd(oprc_pkg::ADDR_GAP, gap_val);
    p = 16'($urandom);
    wr(oprc_pkg::ADDR_BDP_LO, p[7:0]);
    wr(oprc_pkg::ADDR_BDP_HI, p[15:8]);
    wr(8'h40, 8'h5a);
    rd(oprc_pkg::ADDR_BDP_LO, p[7:0]);
    rd(oprc_pkg::ADDR_BDP_HI, p[15:8]);
    rd(8'h40, 8'h00);
    check({9'h0, buffer_descriptor_page}, {9'h0, p});
    wr(oprc_pkg::ADDR_COMMAND, 8'h00);
    rd(oprc_pkg::ADDR_COMMAND, 8'h00);
    // Gap of one unit; 300 bytes cross one burst edge
    wr(oprc_pkg::ADDR_GAP, 8'h01);
    wb_q.push_back({1'b1, 16'h0012, 8'h06});
    stall_n = 0;
    pulse_rx();
    wait_wb();
    check(25'(stall_n), 25'(oprc_pkg::GAP_UNIT_CLOCKS));
    rx_tail <= 16'h0012;
    rd(oprc_pkg::ADDR_STATUS, 8'h02);
    rx_head <= 16'h0012;
    @(posedge sys_clk);
    rd(oprc_pkg::ADDR_STATUS, 8'h02);
    rd(oprc_pkg::ADDR_STATUS, 8'h00);
    rx_free <= 8'h01;
    pkt_len <= 16'd20;
    wr(oprc_pkg::ADDR_IRQ_EN, 8'h04);
    pulse_rx();
    repeat (6) @(posedge sys_clk);
    check({grant, halted, irq}, 25'h3);
    wr(oprc_pkg::ADDR_IRQ_EN, 8'h02);
    @(posedge sys_clk);
    check(25'(irq), 25'h0);
    rd(oprc_pkg::ADDR_STATUS, 8'h04);
    rx_free <= 8'h08;
    wb_q.push_back({1'b1, 16'h0014, 8'h06});
    wr(oprc_pkg::ADDR_COMMAND, 8'h01);
    repeat (3) @(posedge sys_clk);
    check(25'(halted), 25'h0);
    rd(oprc_pkg::ADDR_COMMAND, 8'h00);
    wait_wb();
    // Send against an empty ring, then two real sends
    wr(oprc_pkg::ADDR_COMMAND, 8'h10);
    repeat (4) @(posedge sys_clk);
    rd(oprc_pkg::ADDR_COMMAND, 8'h00);
    rd(oprc_pkg::ADDR_STATUS, 8'h20);
    for (int i = 0; i < 2; i++)
    begin
      hit_cfg <= i[0];
      coll_cfg <= !i[0];
      arp_dly <= i[0] ? 8'h00 : 8'h14;
      tx_tail <= tx_head + 16'h0002;
      wb_q.push_back({1'b0, tx_head + 16'h0002, 8'h02});
      wr(oprc_pkg::ADDR_COMMAND, 8'h10);
      rd(oprc_pkg::ADDR_COMMAND, 8'h10);
      // Status read while the lookup is pending, or in its answer cycle on the second pass
      rd(oprc_pkg::ADDR_STATUS, 8'h00);
      wait_wb();
      check(25'(seen_arp), 25'(!i[0]));
      rd(oprc_pkg::ADDR_COMMAND, 8'h00);
      rd(oprc_pkg::ADDR_STATUS, i[0] ? 8'h40 : 8'h51);
      tx_head <= tx_head + 16'h0002;
      // Head must settle before the next tail is derived from it
      @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    end_sim();
  end
endmodule : offload_packet_ring_control_tb_top
